// ---- pfc_pkg.sv ----
// Purpose: Shared constants and carrier types for the pause flow-control block
// Assumes: One clock domain, APB register access with 32-bit data
// Notes:   All offsets, frame constants and reset values except SWREQ and QSEL live here
package pfc_pkg;

  localparam int NUM_CLASS = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_SWREQ    = 8'h04;
  localparam logic [7:0] REG_QUANTA   = 8'h08;
  localparam logic [7:0] REG_QSEL     = 8'h0C;
  localparam logic [7:0] REG_TXEN     = 8'h10;
  localparam logic [7:0] REG_HOLDOFF  = 8'h14;
  localparam logic [7:0] REG_DADDR_LO = 8'h18;
  localparam logic [7:0] REG_DADDR_HI = 8'h1C;
  localparam logic [7:0] REG_STATUS   = 8'h20;

  // Control register bit positions
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_HONOR = 1;
  localparam int CTRL_PFC   = 2;
  localparam int CTRL_FWD   = 3;
  localparam int CTRL_RETX  = 4;
  localparam int CTRL_W     = 5;

  // Reset values
  localparam logic [4:0]  CTRL_RST    = 5'h13;
  localparam logic [7:0]  TXEN_RST    = 8'hFF;
  localparam logic [15:0] HOLDOFF_RST = 16'h0100;
  localparam logic [15:0] QUANTA_RST  = 16'hFFFF;
  localparam logic [47:0] DADDR_RST   = 48'h010000C28001;

  // Generated frame fields
  localparam logic [47:0] PF_DEST   = 48'h010000C28001;
  localparam logic [15:0] PF_ETYPE  = 16'h8808;
  localparam logic [15:0] OP_STD    = 16'h0001;
  localparam logic [15:0] OP_PFC    = 16'h0101;
  localparam logic [8:0]  PAD_STD   = 9'h150;
  localparam logic [8:0]  PAD_PFC   = 9'h0D0;
  localparam logic [15:0] ZERO_TIME = 16'h0000;

  // Quantum timing: 512 bit times over a 256-bit datapath
  localparam int QUANTUM_BITS  = 512;
  localparam int DATAPATH_BITS = 256;
  localparam logic [3:0] CYC_PER_QUANTUM = 4'(QUANTUM_BITS / DATAPATH_BITS);

  // Decoded received pause frame from the RX MAC
  typedef struct packed {
    logic                            valid;
    logic                            is_pfc;
    logic [47:0]                     daddr;
    logic [NUM_CLASS-1:0]            class_en;
    logic [NUM_CLASS-1:0][15:0]      times;
  } pfc_rx_pause_s;

  // Pause frame handed to the TX datapath for insertion
  typedef struct packed {
    logic                            is_xon;
    logic [47:0]                     dest;
    logic [15:0]                     etype;
    logic [15:0]                     opcode;
    logic [15:0]                     class_en;
    logic [NUM_CLASS-1:0][15:0]      times;
    logic [8:0]                      pad_bits;
  } pfc_tx_frame_s;

endpackage : pfc_pkg

// ---- pfc_flow.sv ----
// Purpose: Pause flow control for a 40G MAC, standard and priority modes
// Assumes: RX decode, TX datapath and client share clk_sys; APB slave registers
// Notes:   Quantum timer ticks every CYC_PER_QUANTUM cycles from a shared phase
`timescale 1ns/1ps
`default_nettype none

module pfc_flow (
  input  wire logic                  clk_sys,      // System clock
  input  wire logic                  rst,          // Synchronous reset, active high
  input  wire logic                  psel,         // APB select
  input  wire logic                  penable,      // APB enable
  input  wire logic                  pwrite,       // APB write
  input  wire logic [7:0]            paddr,        // APB byte address
  input  wire logic [31:0]           pwdata,       // APB write data
  output logic      [31:0]           prdata,       // APB read data
  output logic                       pready,       // APB ready
  output logic                       pslverr,      // APB error on unmapped address
  input  wire pfc_pkg::pfc_rx_pause_s rx_pause,    // Decoded received pause frame
  input  wire logic                  tx_in_frame,  // TX datapath mid-frame
  input  wire logic [7:0]            client_xoff_req, // Client per-class pause request
  output logic      [7:0]            pause_recv,   // Per-class pause in force
  output logic                       tx_hold,      // Client must not send
  output logic                       rx_pf_fwd,    // Forward pause frame to client
  output logic                       rx_pf_drop,   // Discard pause frame
  output logic                       tx_pf_valid,  // Pause frame waiting for insertion
  output pfc_pkg::pfc_tx_frame_s     tx_pf,        // Pause frame content
  input  wire logic                  tx_pf_ready   // TX datapath takes the frame
);

  localparam int NC = pfc_pkg::NUM_CLASS;

  logic [pfc_pkg::CTRL_W-1:0] ctrl_q;
  logic                       sw_req_q;
  logic [2:0]                 qsel_q;
  logic [NC-1:0]              txen_q;
  logic [15:0]                holdoff_q;
  logic [47:0]                daddr_q;
  logic [15:0]                quanta_q [NC];
  logic [31:0]                rd_data;
  logic                       addr_ok;
  logic                       wr_en;
  logic [3:0]                 qphase_q;
  logic                       qtick;
  logic [15:0]                cnt_q [NC];
  logic                       std_pend_q;
  logic [15:0]                std_pend_val_q;
  logic                       rx_match;
  logic                       rx_acc;
  logic [NC-1:0]              req_v;
  logic [NC-1:0]              req_prev_q;
  logic [NC-1:0]              rise;
  logic [NC-1:0]              fall;
  logic [NC-1:0]              xoff_pend_q;
  logic [NC-1:0]              xon_pend_q;
  logic                       launch_xoff;
  logic                       launch_xon;
  logic                       take;
  logic                       retx_fire;
  logic [15:0]                ho_cnt_q;
  logic                       ho_armed_q;
  logic                       pfc_mode;

  assign pfc_mode = ctrl_q[pfc_pkg::CTRL_PFC];
  assign wr_en    = psel && penable && pready && pwrite && addr_ok;

  // Register read mux and address decode
  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      pfc_pkg::REG_CTRL:     rd_data = {27'h0000000, ctrl_q};
      pfc_pkg::REG_SWREQ:    rd_data = {31'h00000000, sw_req_q};
      pfc_pkg::REG_QUANTA:   rd_data = {16'h0000, quanta_q[qsel_q]};
      pfc_pkg::REG_QSEL:     rd_data = {29'h00000000, qsel_q};
      pfc_pkg::REG_TXEN:     rd_data = {24'h000000, txen_q};
      pfc_pkg::REG_HOLDOFF:  rd_data = {16'h0000, holdoff_q};
      pfc_pkg::REG_DADDR_LO: rd_data = daddr_q[31:0];
      pfc_pkg::REG_DADDR_HI: rd_data = {16'h0000, daddr_q[47:32]};
      pfc_pkg::REG_STATUS:   rd_data = {6'h00, tx_pf_valid, xon_pend_q, xoff_pend_q, pause_recv, tx_hold};
      default:               addr_ok = 1'b0;
    endcase
  end

  // APB handshake: one wait-free access phase, data latched in setup
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q    <= pfc_pkg::CTRL_RST;
      sw_req_q  <= 1'b0;
      qsel_q    <= 3'h0;
      txen_q    <= pfc_pkg::TXEN_RST;
      holdoff_q <= pfc_pkg::HOLDOFF_RST;
      daddr_q   <= pfc_pkg::DADDR_RST;
      for (int n = 0; n < NC; n++) begin
        quanta_q[n] <= pfc_pkg::QUANTA_RST;
      end
    end else if (wr_en) begin
      case (paddr)
        pfc_pkg::REG_CTRL:     ctrl_q <= pwdata[pfc_pkg::CTRL_W-1:0];
        pfc_pkg::REG_SWREQ:    sw_req_q <= pwdata[0];
        pfc_pkg::REG_QUANTA:   quanta_q[qsel_q] <= pwdata[15:0];
        pfc_pkg::REG_QSEL:     qsel_q <= pwdata[2:0];
        pfc_pkg::REG_TXEN:     txen_q <= pwdata[NC-1:0];
        pfc_pkg::REG_HOLDOFF:  holdoff_q <= pwdata[15:0];
        pfc_pkg::REG_DADDR_LO: daddr_q[31:0] <= pwdata;
        pfc_pkg::REG_DADDR_HI: daddr_q[47:32] <= pwdata[15:0];
        default:               ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Quantum phase: one tick per quantum of line time
  assign qtick = (qphase_q == pfc_pkg::CYC_PER_QUANTUM - 4'h1);
  always_ff @(posedge clk_sys) begin
    if (rst || qtick) begin
      qphase_q <= 4'h0;
    end else begin
      qphase_q <= qphase_q + 4'h1;
    end
  end

  // Receive qualification: address match, processing on, mode honour
  assign rx_match = rx_pause.valid && (rx_pause.daddr == daddr_q);
  assign rx_acc   = rx_match && ctrl_q[pfc_pkg::CTRL_RX_EN] &&
                    (rx_pause.is_pfc ? pfc_mode : (!pfc_mode && ctrl_q[pfc_pkg::CTRL_HONOR]));

  // Forward or drop decision; unmatched frames always pass
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_pf_fwd  <= 1'b0;
      rx_pf_drop <= 1'b0;
    end else begin
      rx_pf_fwd  <= rx_pause.valid && (!rx_match ||
                    (ctrl_q[pfc_pkg::CTRL_RX_EN] && ctrl_q[pfc_pkg::CTRL_FWD]));
      rx_pf_drop <= rx_pause.valid && rx_match &&
                    !(ctrl_q[pfc_pkg::CTRL_RX_EN] && ctrl_q[pfc_pkg::CTRL_FWD]);
    end
  end

  // Standard pause waits for the current frame before counting
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      std_pend_q     <= 1'b0;
      std_pend_val_q <= 16'h0000;
    end else if (rx_acc && !rx_pause.is_pfc) begin
      std_pend_q     <= (rx_pause.times[0] != pfc_pkg::ZERO_TIME);
      std_pend_val_q <= rx_pause.times[0];
    end else if (std_pend_q && !tx_in_frame) begin
      std_pend_q     <= 1'b0;
    end
  end

  // Per-class pause counters, newest time wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int n = 0; n < NC; n++) begin
        cnt_q[n] <= 16'h0000;
      end
    end else begin
      for (int n = 0; n < NC; n++) begin
        if (rx_acc && rx_pause.is_pfc && rx_pause.class_en[n]) begin
          cnt_q[n] <= rx_pause.times[n];
        end else if (n == 0 && rx_acc && !rx_pause.is_pfc &&
                     rx_pause.times[0] == pfc_pkg::ZERO_TIME) begin
          cnt_q[n] <= 16'h0000;
        end else if (n == 0 && std_pend_q && !tx_in_frame) begin
          cnt_q[n] <= std_pend_val_q;
        end else if (qtick && cnt_q[n] != 16'h0000) begin
          cnt_q[n] <= cnt_q[n] - 16'h0001;
        end
      end
    end
  end

  // Pause status towards the TX client
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pause_recv <= '0;
      tx_hold    <= 1'b0;
    end else begin
      for (int n = 0; n < NC; n++) begin
        pause_recv[n] <= (cnt_q[n] != 16'h0000) && (pfc_mode || n == 0);
      end
      tx_hold <= !pfc_mode && (cnt_q[0] != 16'h0000);
    end
  end

  // Combined request level; a second source cannot make a new edge
  always_comb begin
    if (pfc_mode) begin
      req_v = (client_xoff_req | {NC{sw_req_q}}) & txen_q;
    end else begin
      req_v = {{(NC-1){1'b0}}, (client_xoff_req[0] & txen_q[0]) | sw_req_q};
    end
  end
  assign rise        = req_v & ~req_prev_q;
  assign fall        = ~req_v & req_prev_q;
  assign take        = tx_pf_valid && tx_pf_ready;
  assign launch_xoff = !tx_pf_valid && (|xoff_pend_q);
  assign launch_xon  = !tx_pf_valid && !(|xoff_pend_q) && (|xon_pend_q);
  assign retx_fire   = ctrl_q[pfc_pkg::CTRL_RETX] && ho_armed_q &&
                       (ho_cnt_q == 16'h0000) && (|req_v);

  // Edge tracking and pending frame requests; new requests beat clears
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_prev_q  <= '0;
      xoff_pend_q <= '0;
      xon_pend_q  <= '0;
    end else begin
      req_prev_q  <= req_v;
      xoff_pend_q <= ((launch_xoff ? '0 : xoff_pend_q) & ~fall) | rise |
                     (retx_fire ? req_v : '0);
      xon_pend_q  <= ((launch_xon ? '0 : xon_pend_q) & ~rise) | fall;
    end
  end

  // Hold-off timer restarted by each XOFF that leaves
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ho_cnt_q   <= 16'h0000;
      ho_armed_q <= 1'b0;
    end else if (take && !tx_pf.is_xon) begin
      ho_cnt_q   <= holdoff_q;
      ho_armed_q <= 1'b1;
    end else if (retx_fire || !(|req_v)) begin
      ho_armed_q <= 1'b0;
    end else if (qtick && ho_cnt_q != 16'h0000) begin
      ho_cnt_q   <= ho_cnt_q - 16'h0001;
    end
  end

  // Frame builder; the TX datapath inserts it after its current frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_pf_valid <= 1'b0;
      tx_pf       <= '0;
    end else if (launch_xoff || launch_xon) begin
      tx_pf_valid    <= 1'b1;
      tx_pf.is_xon   <= launch_xon;
      tx_pf.dest     <= pfc_pkg::PF_DEST;
      tx_pf.etype    <= pfc_pkg::PF_ETYPE;
      tx_pf.opcode   <= pfc_mode ? pfc_pkg::OP_PFC : pfc_pkg::OP_STD;
      tx_pf.pad_bits <= pfc_mode ? pfc_pkg::PAD_PFC : pfc_pkg::PAD_STD;
      tx_pf.class_en <= pfc_mode ? {8'h00, (launch_xoff ? xoff_pend_q : xon_pend_q)} : 16'h0000;
      for (int n = 0; n < NC; n++) begin
        tx_pf.times[n] <= (launch_xoff && (pfc_mode ? xoff_pend_q[n] : n == 0)) ?
                          quanta_q[n] : pfc_pkg::ZERO_TIME;
      end
    end else if (take) begin
      tx_pf_valid <= 1'b0;
    end
  end

  // Checks
  a_hold_std_only: assert property (@(posedge clk_sys) disable iff (rst)
    rx_acc && !rx_pause.is_pfc && rx_pause.times[0] != 16'h0000 && !tx_in_frame
    |=> ##2 tx_hold) else $error("standard pause did not hold client");
  a_pfc_no_hold: assert property (@(posedge clk_sys) disable iff (rst)
    rx_acc && rx_pause.is_pfc && rx_pause.class_en[0] && rx_pause.times[0] > 16'h0002
    |=> ##1 (pause_recv[0] && !tx_hold)) else $error("priority pause not reported");
  a_gate_off: assert property (@(posedge clk_sys) disable iff (rst)
    rx_pause.valid && !ctrl_q[pfc_pkg::CTRL_RX_EN] && !std_pend_q && cnt_q[0] == 16'h0000
    |=> !std_pend_q && cnt_q[0] == 16'h0000) else $error("disabled pause changed counter");
  a_frame_wait: assert property (@(posedge clk_sys) disable iff (rst)
    std_pend_q && tx_in_frame && !rx_acc |=> std_pend_q) else $error("pause started mid-frame");
  a_zero_resume: assert property (@(posedge clk_sys) disable iff (rst)
    rx_acc && !rx_pause.is_pfc && rx_pause.times[0] == 16'h0000 |=> ##1 !tx_hold)
    else $error("zero pause time did not resume");
  a_newest_wins: assert property (@(posedge clk_sys) disable iff (rst)
    rx_acc && rx_pause.is_pfc && rx_pause.class_en[2] |=> cnt_q[2] == $past(rx_pause.times[2]))
    else $error("pause time not replaced");
  a_tick_rate: assert property (@(posedge clk_sys) disable iff (rst)
    qtick && cnt_q[2] > 16'h0001 && !(rx_acc && rx_pause.class_en[2])
    ##1 !(rx_acc && rx_pause.class_en[2])
    |=> (cnt_q[2] == $past(cnt_q[2], 2) - 16'h0001) && qtick) else $error("quantum rate wrong");
  a_std_frame: assert property (@(posedge clk_sys) disable iff (rst)
    tx_pf_valid && tx_pf.opcode == pfc_pkg::OP_STD |-> tx_pf.dest == pfc_pkg::PF_DEST &&
    tx_pf.etype == pfc_pkg::PF_ETYPE && (tx_pf.is_xon == (tx_pf.times[0] == 16'h0000) || !tx_pf.is_xon))
    else $error("standard frame fields wrong");
  a_pfc_xon_zero: assert property (@(posedge clk_sys) disable iff (rst)
    tx_pf_valid && tx_pf.is_xon |-> tx_pf.times == '0) else $error("XON carried a pause time");
  a_xoff_on_rise: assert property (@(posedge clk_sys) disable iff (rst)
    rise[0] && !tx_pf_valid && !(|xon_pend_q) |=> xoff_pend_q[0] ##1 (tx_pf_valid && !tx_pf.is_xon))
    else $error("request rise gave no XOFF");
  a_xon_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
    fall[0] |=> xon_pend_q[0]) else $error("request fall gave no XON");
  a_fwd_choice: assert property (@(posedge clk_sys) disable iff (rst)
    rx_match && ctrl_q[pfc_pkg::CTRL_RX_EN] |=> rx_pf_fwd == $past(ctrl_q[pfc_pkg::CTRL_FWD]) && !rx_pf_fwd == rx_pf_drop)
    else $error("pass-through choice ignored");

  // Offered frame holds still; fixed fields per mode
  a_pf_hold: assert property (@(posedge clk_sys) disable iff (rst)
    tx_pf_valid && !tx_pf_ready |=> tx_pf_valid && $stable(tx_pf))
    else $error("offered frame changed");
  a_std_pad: assert property (@(posedge clk_sys) disable iff (rst)
    tx_pf_valid && tx_pf.opcode == pfc_pkg::OP_STD |-> tx_pf.pad_bits == pfc_pkg::PAD_STD)
    else $error("standard pad wrong");
  a_pfc_pad: assert property (@(posedge clk_sys) disable iff (rst)
    tx_pf_valid && tx_pf.opcode == pfc_pkg::OP_PFC |-> tx_pf.pad_bits == pfc_pkg::PAD_PFC)
    else $error("priority pad wrong");
  a_pfc_unmarked: assert property (@(posedge clk_sys) disable iff (rst)
    tx_pf_valid && tx_pf.opcode == pfc_pkg::OP_PFC && !tx_pf.class_en[7] |-> tx_pf.times[7] == pfc_pkg::ZERO_TIME)
    else $error("unmarked class carried a time");

  // Receive side: only marked classes move, mode outputs stay apart
  a_class_only: assert property (@(posedge clk_sys) disable iff (rst)
    rx_acc && rx_pause.is_pfc && !rx_pause.class_en[2] && !qtick |=> cnt_q[2] == $past(cnt_q[2]))
    else $error("unmarked class counter moved");
  a_pfc_nohold: assert property (@(posedge clk_sys) disable iff (rst)
    pfc_mode && $past(pfc_mode) |-> !tx_hold)
    else $error("priority mode held client");
  a_std_upper: assert property (@(posedge clk_sys) disable iff (rst)
    !pfc_mode && !$past(pfc_mode) |-> pause_recv[NC-1:1] == '0)
    else $error("standard mode reported upper class");
  a_std_load: assert property (@(posedge clk_sys) disable iff (rst)
    std_pend_q && !tx_in_frame && !rx_acc |=> !std_pend_q && cnt_q[0] == $past(std_pend_val_q))
    else $error("pending pause not loaded at frame end");

  // Software request queueing and hold-off restart
  a_sw_xoff: assert property (@(posedge clk_sys) disable iff (rst)
    !pfc_mode && sw_req_q && !req_prev_q[0] |=> xoff_pend_q[0])
    else $error("software set queued no XOFF");
  a_sw_xon: assert property (@(posedge clk_sys) disable iff (rst)
    !pfc_mode && !$past(pfc_mode) && $fell(sw_req_q) && !(client_xoff_req[0] && txen_q[0]) |=> xon_pend_q[0])
    else $error("software clear queued no XON");
  a_ho_restart: assert property (@(posedge clk_sys) disable iff (rst)
    take && !tx_pf.is_xon |=> ho_armed_q && ho_cnt_q == $past(holdoff_q))
    else $error("hold-off not restarted by XOFF");

endmodule : pfc_flow
`default_nettype wire

// ---- pfc_txdp_model.sv ----
// Purpose: TX datapath and client model facing the pause block
// Assumes: One clock, frames sent by the bench through fr_start
// Notes:   Pause frames are taken only between client frames
`timescale 1ns/1ps
`default_nettype none
module pfc_txdp_model (
  input  wire logic       clk_sys,     // System clock
  input  wire logic       rst,         // Synchronous reset
  input  wire logic       fr_start,    // Client begins a frame
  input  wire logic [7:0] fr_len,      // Frame length in cycles
  input  wire logic [2:0] fr_class,    // Class of that frame
  input  wire logic [7:0] pause_recv,  // Classes under pause
  input  wire logic       tx_hold,     // Standard pause in force
  input  wire logic       tx_pf_valid, // Pause frame offered
  output logic            tx_in_frame, // Client frame in progress
  output logic            tx_pf_ready  // Pause frame taken
);
  logic [7:0] cnt_q;
  // Client frames; a paused class or a held link sends nothing
  always_ff @(posedge clk_sys) begin
    if (rst)
      cnt_q <= 8'h00;
    else if (fr_start && !tx_hold && !pause_recv[fr_class] && cnt_q == 8'h00)
      cnt_q <= fr_len;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign tx_in_frame = (cnt_q != 8'h00);
  // One-cycle take at a frame boundary, so a frame is never split
  always_ff @(posedge clk_sys) begin
    if (rst)
      tx_pf_ready <= 1'b0;
    else
      tx_pf_ready <= tx_pf_valid && !tx_in_frame && !tx_pf_ready && !fr_start;
  end
endmodule : pfc_txdp_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the pause flow-control block
// Assumes: APB with zero wait states, 200 MHz clock
// Notes:   Frames are captured at the edge where they are taken
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [47:0] DA = 48'h010000C28001;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, client_xoff_req, pause_recv, fr_len;
  logic [31:0] pwdata, prdata, rd;
  logic tx_in_frame, tx_hold, rx_pf_fwd, rx_pf_drop, tx_pf_valid, tx_pf_ready, fr_start, er;
  logic [2:0] fr_class;
  pfc_pkg::pfc_rx_pause_s rx_pause;
  pfc_pkg::pfc_tx_frame_s tx_pf, pf_got;
  int error_cnt, n_checks, pf_cnt, fwd_n, drop_n, cyc;
  pfc_flow dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pause(rx_pause), .tx_in_frame(tx_in_frame), .client_xoff_req(client_xoff_req),
    .pause_recv(pause_recv), .tx_hold(tx_hold), .rx_pf_fwd(rx_pf_fwd), .rx_pf_drop(rx_pf_drop),
    .tx_pf_valid(tx_pf_valid), .tx_pf(tx_pf), .tx_pf_ready(tx_pf_ready));
  pfc_txdp_model mdl (.clk_sys(clk_sys), .rst(rst), .fr_start(fr_start), .fr_len(fr_len),
    .fr_class(fr_class), .pause_recv(pause_recv), .tx_hold(tx_hold), .tx_pf_valid(tx_pf_valid),
    .tx_in_frame(tx_in_frame), .tx_pf_ready(tx_pf_ready));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Frame capture and event counts
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    fwd_n <= fwd_n + int'(rx_pf_fwd);
    drop_n <= drop_n + int'(rx_pf_drop);
    if (tx_pf_valid === 1'b1 && tx_pf_ready === 1'b1) begin
      pf_got <= tx_pf;
      pf_cnt <= pf_cnt + 1;
    end
  end
  task chk(input string s, input logic [127:0] e, input logic [127:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // APB master: setup, access, hold until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("apb ready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("reg read", e, rd);
  endtask : rdchk
  task rx(input logic p, input logic [47:0] da, input logic [7:0] ce, input logic [15:0] t);
    pfc_pkg::pfc_rx_pause_s r;
    r.valid = 1'b1; r.is_pfc = p; r.daddr = da; r.class_en = ce; r.times = {8{t}};
    @(posedge clk_sys);
    rx_pause <= r;
    @(posedge clk_sys);
    rx_pause.valid <= 1'b0;
  endtask : rx
  task wait_pf(output pfc_pkg::pfc_tx_frame_s f);
    int n0, k;
    n0 = pf_cnt; k = 0;
    while (pf_cnt == n0 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    f = pf_got;
    chk("frame sent", 1, pf_cnt != n0);
  endtask : wait_pf
  // Count cycles until tx_hold falls, bounded
  task hold_len(output int n);
    n = 0;
    while (tx_hold === 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : hold_len
  task t_regs;
    rdchk(pfc_pkg::REG_CTRL, 32'h13); rdchk(pfc_pkg::REG_TXEN, 32'hFF);
    rdchk(pfc_pkg::REG_HOLDOFF, 32'h100); rdchk(pfc_pkg::REG_DADDR_LO, 32'h00C28001);
    rdchk(pfc_pkg::REG_DADDR_HI, 32'h0100); rdchk(pfc_pkg::REG_SWREQ, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 1, er);
    $display("test regs done");
  endtask : t_regs
  task t_std_rx;
    int n;
    @(posedge clk_sys); fr_start <= 1'b1; fr_len <= 8'd6;
    @(posedge clk_sys); fr_start <= 1'b0;
    rx(1'b0, DA, 8'h01, 16'd5);
    repeat (3) begin @(posedge clk_sys); chk("hold mid frame", 0, tx_hold); end
    n = 0;
    while (tx_hold !== 1'b1 && n < 10) begin @(posedge clk_sys); n++; end
    chk("hold rise", 1, tx_hold);
    hold_len(n);
    chk("hold len", 1, n >= 5 * 2 - 2 && n <= 5 * 2 + 1);
    rx(1'b0, DA, 8'h01, 16'd100); repeat (6) @(posedge clk_sys);
    rx(1'b0, DA, 8'h01, 16'd3); hold_len(n);
    chk("newest time", 1, n <= 3 * 2 + 4);
    rx(1'b0, DA, 8'h01, 16'd100); repeat (6) @(posedge clk_sys);
    rx(1'b0, DA, 8'h01, 16'd0); hold_len(n);
    chk("zero resumes", 1, n <= 4);
    $display("test std_rx done");
  endtask : t_std_rx
  task t_refuse;
    int d0;
    d0 = drop_n;
    apb(1'b1, pfc_pkg::REG_CTRL, 32'h12);
    rx(1'b0, DA, 8'h01, 16'd50); repeat (4) @(posedge clk_sys);
    chk("rx off", 0, tx_hold);
    chk("off dropped", 1, drop_n == d0 + 1);
    d0 = drop_n;
    apb(1'b1, pfc_pkg::REG_CTRL, 32'h11);
    rx(1'b0, DA, 8'h01, 16'd50); repeat (4) @(posedge clk_sys);
    chk("honor off", 0, tx_hold);
    chk("dropped", 1, drop_n == d0 + 1);
    apb(1'b1, pfc_pkg::REG_CTRL, 32'h1B); d0 = fwd_n;
    rx(1'b0, DA ^ 48'h1, 8'h01, 16'd50); repeat (4) @(posedge clk_sys);
    chk("addr miss", 0, tx_hold);
    chk("miss passed", 1, fwd_n == d0 + 1);
    d0 = fwd_n;
    rx(1'b0, DA, 8'h01, 16'd0); repeat (3) @(posedge clk_sys);
    chk("forwarded", 1, fwd_n == d0 + 1);
    apb(1'b1, pfc_pkg::REG_CTRL, 32'h13);
    $display("test refuse done");
  endtask : t_refuse
  task t_tx_std;
    pfc_pkg::pfc_tx_frame_s f;
    apb(1'b1, pfc_pkg::REG_QSEL, 32'h0); apb(1'b1, pfc_pkg::REG_QUANTA, 32'h0123);
    client_xoff_req <= 8'h01; wait_pf(f);
    chk("xoff kind", 0, f.is_xon); chk("dest", DA, f.dest);
    chk("etype", 16'h8808, f.etype); chk("opcode", 16'h0001, f.opcode);
    chk("time0", 16'h0123, f.times[0]); chk("pad", 9'd336, f.pad_bits);
    client_xoff_req <= 8'h00; wait_pf(f);
    chk("xon kind", 1, f.is_xon); chk("xon time", 0, f.times[0]);
    apb(1'b1, pfc_pkg::REG_SWREQ, 32'h1); wait_pf(f);
    chk("sw xoff", 0, f.is_xon);
    apb(1'b1, pfc_pkg::REG_SWREQ, 32'h0); wait_pf(f);
    chk("sw xon", 1, f.is_xon);
    $display("test tx_std done");
  endtask : t_tx_std
  task t_tx_pfc;
    pfc_pkg::pfc_tx_frame_s f;
    apb(1'b1, pfc_pkg::REG_CTRL, 32'h17); apb(1'b1, pfc_pkg::REG_TXEN, 32'h0F);
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, pfc_pkg::REG_QSEL, 32'(n)); apb(1'b1, pfc_pkg::REG_QUANTA, 32'h0200 + 32'(n));
    end
    apb(1'b1, pfc_pkg::REG_QSEL, 32'h3); rdchk(pfc_pkg::REG_QUANTA, 32'h0203);
    client_xoff_req <= 8'h3C; wait_pf(f);
    chk("pfc op", 16'h0101, f.opcode); chk("xoff vec", 16'h000C, f.class_en);
    chk("time2", 16'h0202, f.times[2]); chk("time3", 16'h0203, f.times[3]);
    chk("pfc pad", 9'd208, f.pad_bits);
    client_xoff_req <= 8'h00; wait_pf(f);
    chk("xon vec", 16'h000C, f.class_en); chk("xon times", 128'h0, f.times);
    $display("test tx_pfc done");
  endtask : t_tx_pfc
  task t_pfc_rx;
    int n;
    rx(1'b1, DA, 8'h05, 16'd40); repeat (4) @(posedge clk_sys);
    chk("classes", 8'h05, pause_recv); chk("no hold", 0, tx_hold);
    rx(1'b1, DA, 8'h01, 16'd0); repeat (4) @(posedge clk_sys);
    chk("class0 resumed", 8'h04, pause_recv);
    n = 0;
    while (pause_recv !== 8'h00 && n < 200) begin @(posedge clk_sys); n++; end
    chk("pause ends", 1, n <= 40 * 2 + 2);
    $display("test pfc_rx done");
  endtask : t_pfc_rx
  task t_retx;
    pfc_pkg::pfc_tx_frame_s f;
    int t0;
    apb(1'b1, pfc_pkg::REG_CTRL, 32'h13); apb(1'b1, pfc_pkg::REG_HOLDOFF, 32'h4);
    client_xoff_req <= 8'h01; wait_pf(f); t0 = cyc;
    wait_pf(f);
    chk("retx xoff", 0, f.is_xon); chk("retx gap", 1, cyc - t0 >= 7 && cyc - t0 <= 16);
    t0 = cyc; apb(1'b1, pfc_pkg::REG_SWREQ, 32'h1); wait_pf(f);
    chk("no extra xoff", 1, cyc - t0 >= 10);
    $display("test retx done");
  endtask : t_retx
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end
  // Main sequence
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    rx_pause = '0; client_xoff_req = 8'h00; fr_start = 1'b0; fr_len = 8'h00; fr_class = 3'h0;
    error_cnt = 0; n_checks = 0; pf_cnt = 0; fwd_n = 0; drop_n = 0; cyc = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs(); t_std_rx(); t_refuse(); t_tx_std(); t_tx_pfc(); t_pfc_rx(); t_retx();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
